// file: shared/pft_pkg.sv
// Package with constants and types of the power supervisor and temperature readout.
// Contract
// - Overtemp, boost, inverter or input undervoltage disables all rails and returns to standby.
// - Global fault powers rails down in fixed order; power-good drops at once.
// - Single rail undervoltage disables that rail and dependents; converters stay up.
// - Rail enables act on edges only; a held high level never restarts.
// - Power-good released only when all four rails enabled and in regulation.
// - Temperature reading refreshes automatically every 60 seconds.
// - Thermistor voltage sampled by a 10-bit successive-approximation converter.
// - Result is 8-bit two's complement degrees; 0 gives 0x00, 25 gives 0x19.
// - Reading saturates at 0xf6 below minus ten and 0x55 above 85.
// - Bare address with read bit returns the temperature byte.
// - Write address, pointer, repeated start and read returns the addressed register.
// - After start shift in address, compare, acknowledge only on match.
// - Start is data falling with clock high; stop is data rising with clock high.
// - Data changes only while the serial clock is low, except start and stop.
// - Acknowledge every valid address, pointer and data byte received.
// - A transaction ends on stop or after the data word is transferred.
// - Serial data is only pulled low, never driven high.
// - Offset 0x00 holds the read-only temperature byte without reset value.
// - Latest result stays in the register until the next conversion; host may trigger.
// - Positive source needs negative source good; regulators and pumps need boost good.
package pft_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int REFRESH_S = 60;
  localparam longint REFRESH_CYC = longint'(REFRESH_S) * CLK_HZ;
  localparam logic [7:0] REG_TEMP = 8'h00;
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h48;
  localparam logic [7:0] TEMP_MIN = 8'hf6;
  localparam logic [7:0] TEMP_MAX = 8'h55;
  localparam int ADC_BITS = 10;
  // Converter code that stands for minus ten degrees, one degree per eight codes above it.
  localparam logic [9:0] ADC_ZERO_CODE = 10'h0a;
  localparam logic [9:0] ADC_STEP = 10'h008;
  localparam int RAIL_N = 4;
  // Rail indices: negative source, negative gate, positive source, positive gate.
  localparam int RAIL_NSRC = 0;
  localparam int RAIL_NGATE = 1;
  localparam int RAIL_PSRC = 2;
  localparam int RAIL_PGATE = 3;
  // Power-down order runs from the highest index to the lowest.
  localparam logic [7:0] DOWN_STEP_CYC = 8'h10;

  typedef struct packed {
    logic overtemp_shutdown;
    logic pos_boost_undervolt;
    logic inv_conv_undervolt;
    logic input_undervolt_lockout;
  } pft_gfault_t;

  typedef struct packed {
    logic pos_gate_undervolt;
    logic pos_source_undervolt;
    logic neg_gate_undervolt;
    logic neg_source_undervolt;
  } pft_rfault_t;

  typedef enum logic [1:0] {
    PFT_STANDBY = 2'b00,
    PFT_ACTIVE = 2'b01,
    PFT_DOWN = 2'b10
  } pft_mode_t;

  typedef enum logic [2:0] {
    PFT_I_IDLE = 3'b000,
    PFT_I_ADDR = 3'b001,
    PFT_I_AACK = 3'b010,
    PFT_I_WBYTE = 3'b011,
    PFT_I_WACK = 3'b100,
    PFT_I_RBYTE = 3'b101,
    PFT_I_RACK = 3'b110
  } pft_i2c_t;
endpackage : pft_pkg

// file: hw/pft_sync.sv
// Three-stage synchroniser with agreement filter for one pin.
`timescale 1ns/1ns
module pft_sync (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Pin and filtered level.
  input wire logic pin,
  output logic level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      level <= 1'b1;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level <= s3_q;
      end
    end
  end
endmodule : pft_sync

// file: hw/pft_sar.sv
// Ten-bit successive-approximation control and translation to degrees.
`timescale 1ns/1ns
module pft_sar
  import pft_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Conversion request and comparator.
  input wire logic start,
  input wire logic cmp_above,
  // Trial code to the DAC and result.
  output logic [ADC_BITS-1:0] dac_code,
  output logic done,
  output logic [7:0] temp
);
  logic [ADC_BITS-1:0] code_q;
  logic [3:0] bit_q;
  logic busy_q;
  logic [9:0] diff;
  logic [9:0] deg;
  assign dac_code = code_q;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      code_q <= '0;
      bit_q <= 4'h0;
      busy_q <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy_q && start) begin
        busy_q <= 1'b1;
        bit_q <= 4'h9;
        code_q <= 10'h200;
      end else if (busy_q) begin
        // Keep the trial bit while the input lies above the trial level.
        if (!cmp_above) begin
          code_q[bit_q] <= 1'b0;
        end
        if (bit_q == 4'h0) begin
          busy_q <= 1'b0;
          done <= 1'b1;
        end else begin
          code_q[bit_q - 4'h1] <= 1'b1;
          bit_q <= bit_q - 4'h1;
        end
      end
    end
  end
  always_comb begin
    diff = code_q - ADC_ZERO_CODE;
    deg = diff / ADC_STEP;
    // Saturate at both ends of the range.
    if (code_q <= ADC_ZERO_CODE) begin
      temp = TEMP_MIN;
    end else if (deg >= 10'd95) begin
      temp = TEMP_MAX;
    end else begin
      temp = deg[7:0] + TEMP_MIN;
    end
  end
endmodule : pft_sar

// file: hw/pft_top.sv
// Fault supervisor, power-good, temperature readout and serial slave.
`timescale 1ns/1ns
module pft_top
  import pft_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEF,
  parameter longint REFRESH_CYCLES = REFRESH_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Rail enable pins and fault inputs.
  input wire logic [3:0] rail_enable_pin,
  input wire pft_pkg::pft_gfault_t gfault,
  input wire pft_pkg::pft_rfault_t rfault,
  input wire logic boost_good,
  input wire logic [3:0] rail_in_reg,
  // Rail enables to the regulators and mode.
  output logic [3:0] rail_en,
  output logic conv_en,
  output logic standby,
  // Open-drain power-good.
  output logic rails_ok_out_o,
  output logic rails_ok_out_oe,
  // Thermistor converter.
  input wire logic conv_trigger,
  input wire logic cmp_above,
  output logic [ADC_BITS-1:0] dac_code,
  // Serial bus pins.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  import pft_pkg::*;

  // Rail supervisor.
  logic [3:0] en_prev_q;
  logic [3:0] rail_q;
  pft_mode_t mode_q;
  logic [7:0] step_q;
  logic gf;
  logic [3:0] rf;
  logic [3:0] dep_kill;
  logic [3:0] rise;

  assign gf = |gfault;
  assign rf = rfault;
  assign rise = rail_enable_pin & ~en_prev_q;

  // A failing rail takes its dependents with it.
  always_comb begin
    dep_kill = rf;
    if (rf[RAIL_NSRC]) begin
      dep_kill[RAIL_PSRC] = 1'b1;
    end
    if (!boost_good) begin
      dep_kill = 4'hf;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      en_prev_q <= 4'h0;
    end else begin
      en_prev_q <= rail_enable_pin;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rail_q <= 4'h0;
      mode_q <= PFT_STANDBY;
      step_q <= 8'h00;
    end else begin
      case (mode_q)
        PFT_STANDBY, PFT_ACTIVE: begin
          if (gf && rail_q != 4'h0) begin
            mode_q <= PFT_DOWN;
            step_q <= DOWN_STEP_CYC;
          end else if (!gf) begin
            // Only a fresh rising edge turns a rail on; falling edges turn it off.
            rail_q <= (rail_q | rise) & rail_enable_pin & ~dep_kill;
            if (rf != 4'h0 && boost_good) begin
              mode_q <= PFT_ACTIVE;
            end else begin
              mode_q <= (((rail_q | rise) & rail_enable_pin) != 4'h0) ? PFT_ACTIVE
                                                                       : PFT_STANDBY;
            end
          end
        end
        PFT_DOWN: begin
          // Drop the highest rail still on, one at a time.
          if (step_q != 8'h00) begin
            step_q <= step_q - 8'h01;
          end else if (rail_q[RAIL_PGATE]) begin
            rail_q[RAIL_PGATE] <= 1'b0;
            step_q <= DOWN_STEP_CYC;
          end else if (rail_q[RAIL_PSRC]) begin
            rail_q[RAIL_PSRC] <= 1'b0;
            step_q <= DOWN_STEP_CYC;
          end else if (rail_q[RAIL_NGATE]) begin
            rail_q[RAIL_NGATE] <= 1'b0;
            step_q <= DOWN_STEP_CYC;
          end else begin
            rail_q <= 4'h0;
            mode_q <= PFT_STANDBY;
          end
        end
        default: mode_q <= PFT_STANDBY;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rail_en <= 4'h0;
      conv_en <= 1'b0;
      standby <= 1'b1;
      rails_ok_out_oe <= 1'b1;
      rails_ok_out_o <= 1'b0;
    end else begin
      rail_en <= rail_q;
      conv_en <= (rail_q != 4'h0) && !gf;
      standby <= (mode_q == PFT_STANDBY);
      rails_ok_out_o <= 1'b0;
      // Release only with all rails on, in regulation and no fault.
      rails_ok_out_oe <= !((rail_q == 4'hf) && (rail_in_reg == 4'hf) && !gf && rf == 4'h0
                          && mode_q == PFT_ACTIVE);
    end
  end

  // Temperature refresh and storage.
  logic [39:0] tick_q;
  logic conv_start;
  logic conv_done;
  logic [7:0] conv_temp;
  logic [7:0] temp_reading_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tick_q <= 40'h0;
    end else if (tick_q >= 40'(REFRESH_CYCLES - 1)) begin
      tick_q <= 40'h0;
    end else begin
      tick_q <= tick_q + 40'h1;
    end
  end
  assign conv_start = (tick_q == 40'h0) || conv_trigger;

  pft_sar u_sar (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(conv_start),
    .cmp_above(cmp_above),
    .dac_code(dac_code),
    .done(conv_done),
    .temp(conv_temp)
  );

  // No reset: the reading has no defined value until the first conversion.
  always_ff @(posedge clk_sys) begin
    if (conv_done) begin
      temp_reading_q <= conv_temp;
    end
  end

  // Serial slave.
  logic scl_s;
  logic sda_s;
  logic scl_p_q;
  logic sda_p_q;
  pft_sync u_scl (.clk_sys(clk_sys), .reset(reset), .pin(scl_i), .level(scl_s));
  pft_sync u_sda (.clk_sys(clk_sys), .reset(reset), .pin(sda_i), .level(sda_s));

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end
  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;
  assign start_c = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_c = scl_s && scl_p_q && !sda_p_q && sda_s;

  pft_i2c_t ist_q;
  logic [7:0] sh_q;
  logic [2:0] cnt_q;
  // Set once eight bits are in, so that an all-zero pointer byte is still taken.
  logic full_q;
  logic ptr_next_q;
  logic [7:0] ptr_q;
  logic [7:0] rd_data;

  assign rd_data = (ptr_q == REG_TEMP) ? temp_reading_q : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ist_q <= PFT_I_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 3'h0;
      full_q <= 1'b0;
      ptr_next_q <= 1'b0;
      ptr_q <= REG_TEMP;
      sda_oe <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      if (stop_c) begin
        ist_q <= PFT_I_IDLE;
        sda_oe <= 1'b0;
        ptr_q <= REG_TEMP;
      end else if (start_c) begin
        ist_q <= PFT_I_ADDR;
        cnt_q <= 3'h0;
        sh_q <= 8'h00;
        full_q <= 1'b0;
        sda_oe <= 1'b0;
      end else begin
        case (ist_q)
          PFT_I_IDLE: sda_oe <= 1'b0;
          PFT_I_ADDR, PFT_I_WBYTE: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == 3'h7) begin
                full_q <= 1'b1;
              end
            end
            if (scl_fall && full_q) begin
              full_q <= 1'b0;
              if (ist_q == PFT_I_ADDR) begin
                if (sh_q[7:1] == SLAVE_ADDR) begin
                  ist_q <= PFT_I_AACK;
                  sda_oe <= 1'b1;
                end else begin
                  ist_q <= PFT_I_IDLE;
                end
              end else begin
                ist_q <= PFT_I_WACK;
                sda_oe <= 1'b1;
                if (ptr_next_q) begin
                  ptr_q <= sh_q;
                end
                ptr_next_q <= 1'b0;
              end
            end
          end
          PFT_I_AACK, PFT_I_WACK: begin
            // Release after the acknowledge clock; load read data while clock is low.
            if (scl_fall) begin
              cnt_q <= 3'h0;
              sh_q <= 8'h00;
              if (ist_q == PFT_I_AACK && sh_q[0]) begin
                ist_q <= PFT_I_RBYTE;
                sh_q <= {rd_data[6:0], 1'b1};
                sda_oe <= !rd_data[7];
              end else begin
                if (ist_q == PFT_I_AACK) begin
                  ptr_next_q <= 1'b1;
                end
                ist_q <= PFT_I_WBYTE;
                sda_oe <= 1'b0;
              end
            end
          end
          PFT_I_RBYTE: begin
            if (scl_fall) begin
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == 3'h7) begin
                ist_q <= PFT_I_RACK;
                sda_oe <= 1'b0;
              end else begin
                sda_oe <= !sh_q[7];
                sh_q <= {sh_q[6:0], 1'b1};
              end
            end
          end
          PFT_I_RACK: begin
            // One data word ends the transfer whatever the master answers.
            if (scl_fall) begin
              ist_q <= PFT_I_IDLE;
            end
          end
          default: ist_q <= PFT_I_IDLE;
        endcase
      end
    end
  end

  global_down_a: assert property (@(posedge clk_sys) disable iff (reset)
    gf && rail_q != 4'h0 && mode_q != PFT_DOWN |=> mode_q == PFT_DOWN)
    else $error("Global fault did not start power-down.");
  good_drop_a: assert property (@(posedge clk_sys) disable iff (reset)
    gf |=> rails_ok_out_oe)
    else $error("Power-good not pulled low on global fault.");
  rail_fault_a: assert property (@(posedge clk_sys) disable iff (reset)
    rf[RAIL_NSRC] && !gf && mode_q != PFT_DOWN |=> !rail_q[RAIL_NSRC] && !rail_q[RAIL_PSRC])
    else $error("Faulted rail or dependent stayed on.");
  edge_only_a: assert property (@(posedge clk_sys) disable iff (reset)
    !rail_q[0] && en_prev_q[0] && rail_enable_pin[0] ##1 mode_q != PFT_DOWN |-> !rail_q[0])
    else $error("Held enable restarted a rail.");
  good_release_a: assert property (@(posedge clk_sys) disable iff (reset)
    !rails_ok_out_oe |-> $past(rail_q) == 4'hf)
    else $error("Power-good released with a rail off.");
  od_only_a: assert property (@(posedge clk_sys) disable iff (reset)
    !sda_o && !rails_ok_out_o)
    else $error("Open-drain pin driven high.");
  nack_other_a: assert property (@(posedge clk_sys) disable iff (reset)
    ist_q == PFT_I_ADDR && scl_fall && full_q
    && sh_q[7:1] != SLAVE_ADDR && !start_c && !stop_c |=> !sda_oe)
    else $error("Acknowledged a foreign address.");
  stop_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
    stop_c |=> ist_q == PFT_I_IDLE && !sda_oe ##1 ist_q == PFT_I_IDLE)
    else $error("Stop did not end the transfer.");
endmodule : pft_top

// file: dv/pft_host.sv
// Two-wire bus master that stands in for the host controller.
`timescale 1ns/1ns
module pft_host (
  // Clock.
  input wire logic clk_sys,
  // Bus wires; the bench resolves the data line with its pull-up.
  input wire logic sda_wire,
  output logic scl,
  output logic sda_oe
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // Start or repeated start; the long low phase lets the slave release first.
  task automatic start_cond();
    tick(4);
    sda_oe = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_oe = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    tick(4);
    sda_oe = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_oe = 1'b0;
    tick(4);
  endtask : stop_cond

  // One bit of 800 ns; the low phase is long because the slave sees the clock late.
  task automatic bit_x(input logic b, output logic s);
    tick(3);
    sda_oe = ~b;
    tick(3);
    scl = 1'b1;
    tick(2);
    s = sda_wire;
    scl = 1'b0;
  endtask : bit_x

  // One byte, most significant bit first, then the acknowledge slot.
  task automatic byte_x(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                        output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
    bit_x(ack_in, ack_out);
  endtask : byte_x
endmodule : pft_host

// file: dv/pft_top_tb_top.sv
// Self-checking bench for the power supervisor and temperature readout.
`timescale 1ns/1ns
module pft_top_tb_top;
  import pft_pkg::*;
  localparam logic [6:0] ADDR = SLAVE_ADDR_DEF;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [3:0] rail_enable_pin = 4'h0;
  pft_gfault_t gfault = '0;
  pft_rfault_t rfault = '0;
  logic boost_good = 1'b1;
  logic [3:0] rail_in_reg = 4'hf;
  logic conv_trigger = 1'b0;
  logic [9:0] therm_code = 10'h05e;
  logic [3:0] rail_en;
  logic [9:0] dac_code;
  logic conv_en, standby, ok_o, ok_oe, scl, sda_o, sda_oe, host_oe, sda_wire, cmp_above;
  logic hi_seen = 1'b0;
  int err_count = 0;
  int cmp_count = 0;

  always #50 clk_sys = ~clk_sys;
  // Comparator of the thermistor voltage against the trial code.
  assign cmp_above = therm_code > dac_code;
  assign sda_wire = (sda_oe ? sda_o : 1'b1) & ~host_oe;

  pft_top #(.SLAVE_ADDR(ADDR), .REFRESH_CYCLES(1000)) pft_top_inst (
    .clk_sys(clk_sys), .reset(reset), .rail_enable_pin(rail_enable_pin), .gfault(gfault),
    .rfault(rfault), .boost_good(boost_good), .rail_in_reg(rail_in_reg), .rail_en(rail_en),
    .conv_en(conv_en), .standby(standby), .rails_ok_out_o(ok_o), .rails_ok_out_oe(ok_oe),
    .conv_trigger(conv_trigger), .cmp_above(cmp_above), .dac_code(dac_code), .scl_i(scl),
    .sda_i(sda_wire), .sda_o(sda_o), .sda_oe(sda_oe));

  pft_host pft_host_inst (.clk_sys(clk_sys), .sda_wire(sda_wire), .scl(scl), .sda_oe(host_oe));

  // Open-drain pins must never show a driven high level.
  always @(posedge clk_sys) begin
    if ((sda_oe && sda_o !== 1'b0) || (ok_oe && ok_o !== 1'b0)) begin
      hi_seen <= 1'b1;
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("Comparisons: %0d, mismatches: %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // Drops every enable pin, then raises them one by one in rail order.
  task automatic rails_up();
    rail_enable_pin = 4'h0;
    step(3);
    for (int i = 0; i < 4; i++) begin
      rail_enable_pin[i] = 1'b1;
      step(4);
    end
    step(6);
  endtask : rails_up

  task automatic read_bare(output logic [7:0] d, output logic ack);
    logic [7:0] rx;
    logic nak;
    pft_host_inst.start_cond();
    pft_host_inst.byte_x({ADDR, 1'b1}, 1'b1, rx, ack);
    pft_host_inst.byte_x(8'hff, 1'b1, d, nak);
    pft_host_inst.stop_cond();
  endtask : read_bare

  // Pointer write, an optional data byte, then repeated start and read.
  task automatic read_ptr(input logic extra, output logic [7:0] d, output logic [3:0] acks);
    logic [7:0] rx;
    logic nak;
    acks = 4'h0;
    pft_host_inst.start_cond();
    pft_host_inst.byte_x({ADDR, 1'b0}, 1'b1, rx, acks[0]);
    pft_host_inst.byte_x(REG_TEMP, 1'b1, rx, acks[1]);
    if (extra) begin
      pft_host_inst.byte_x(8'ha5, 1'b1, rx, acks[2]);
    end
    pft_host_inst.start_cond();
    pft_host_inst.byte_x({ADDR, 1'b1}, 1'b1, rx, acks[3]);
    pft_host_inst.byte_x(8'hff, 1'b1, d, nak);
    pft_host_inst.stop_cond();
  endtask : read_ptr

  initial begin : main
    logic [7:0] d;
    logic ack;
    logic [3:0] acks;
    logic [3:0] prev;
    logic order_ok;
    logic [9:0] codes [7] = '{10'h003, 10'h00e, 10'h056, 10'h05e, 10'h126, 10'h306, 10'h3e8};
    logic [7:0] temps [7] = '{8'hf6, 8'hf6, 8'hff, 8'h00, 8'h19, 8'h55, 8'h55};
    step(4);
    reset = 1'b0;
    step(6);
    rail_enable_pin[0] = 1'b1;
    step(3);
    check(8'(rail_en), 8'h01, "single rail");
    check(8'(ok_oe), 8'h01, "pgood partial");
    rails_up();
    check(8'(rail_en), 8'h0f, "all rails");
    check(8'({conv_en, standby}), 8'h02, "active mode");
    check(8'(ok_oe), 8'h00, "pgood released");
    rail_in_reg[1] = 1'b0;
    step(3);
    check(8'(ok_oe), 8'h01, "pgood out of regulation");
    rail_in_reg[1] = 1'b1;
    step(3);
    check(8'(ok_oe), 8'h00, "pgood back");
    rfault.neg_source_undervolt = 1'b1;
    step(4);
    rfault = '0;
    step(10);
    check(8'(rail_en), 8'h0a, "dependent shutdown");
    check(8'({conv_en, standby, ok_oe}), 8'h05, "converters stay up");
    rail_enable_pin[0] = 1'b0;
    rail_enable_pin[2] = 1'b0;
    step(3);
    rail_enable_pin[0] = 1'b1;
    step(4);
    rail_enable_pin[2] = 1'b1;
    step(4);
    check(8'(rail_en), 8'h0f, "restart by toggle");
    for (int g = 0; g < 4; g++) begin
      gfault = pft_gfault_t'(4'h1 << g);
      step(2);
      check(8'(ok_oe), 8'h01, "pgood on global fault");
      prev = 4'hf;
      order_ok = 1'b1;
      repeat (90) begin
        step(1);
        if (rail_en !== prev) begin
          order_ok = order_ok & (rail_en === (prev >> 1));
          prev = rail_en;
        end
      end
      check(8'(order_ok), 8'h01, "power-down order");
      check(8'({rail_en, conv_en, standby}), 8'h01, "standby after fault");
      gfault = '0;
      step(5);
      check(8'(rail_en), 8'h00, "no restart on level");
      rails_up();
    end
    for (int i = 0; i < 7; i++) begin
      therm_code = codes[i];
      // Held past one conversion so that a periodic one in flight cannot swallow it.
      conv_trigger = 1'b1;
      step(24);
      conv_trigger = 1'b0;
      step(40);
      read_bare(d, ack);
      check(8'(ack), 8'h00, "address ack");
      check(d, temps[i], "temperature");
    end
    read_ptr(1'b0, d, acks);
    check(8'(acks), 8'h00, "pointer read acks");
    check(d, 8'h55, "pointer read data");
    read_ptr(1'b1, d, acks);
    check(8'(acks), 8'h00, "extra byte acks");
    check(d, 8'h55, "read-only value kept");
    pft_host_inst.start_cond();
    pft_host_inst.byte_x({ADDR ^ 7'h01, 1'b1}, 1'b1, d, ack);
    pft_host_inst.stop_cond();
    check(8'(ack), 8'h01, "foreign address");
    check(8'(sda_oe), 8'h00, "line released");
    therm_code = 10'h126;
    step(1100);
    read_bare(d, ack);
    check(d, 8'h19, "periodic refresh");
    check(8'(hi_seen), 8'h00, "open drain only");
    complete_run();
  end

  initial begin : watchdog
    repeat (30000) @(posedge clk_sys);
    err_count++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    complete_run();
  end
endmodule : pft_top_tb_top
